// >>> logic/acmc_map.vh
// Constants for the conversion-mode register bank: offsets, field positions,
// reset values and start-delay times.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ACMC_MAP_VH
`define ACMC_MAP_VH

// ==========================================================
// Register offsets
`define ACMC_ADDR_RATE_FILT 8'h02
`define ACMC_ADDR_CONV_CTRL 8'h03
`define ACMC_ADDR_AUX_PIN 8'h04

// ==========================================================
// Reset values
`define ACMC_RST_RATE_FILT 8'h24
`define ACMC_RST_CONV_CTRL 8'h01
`define ACMC_RST_AUX_PIN 8'h00
`define ACMC_RST_RDATA 8'h00

// ==========================================================
// Field positions
`define ACMC_RATE_MSB 7
`define ACMC_RATE_LSB 3
`define ACMC_FILT_MSB 2
`define ACMC_FILT_LSB 0
`define ACMC_RSVD_BIT 7
`define ACMC_CHOP_MSB 6
`define ACMC_CHOP_LSB 5
`define ACMC_SHOT_BIT 4
`define ACMC_DLY_MSB 3
`define ACMC_DLY_LSB 0
`define ACMC_LINK_MSB 7
`define ACMC_LINK_LSB 4
`define ACMC_DIR_MSB 3
`define ACMC_DIR_LSB 0

// ==========================================================
// Field codes
`define ACMC_FILT_SINC1 3'h0
`define ACMC_FILT_SINC2 3'h1
`define ACMC_FILT_SINC3 3'h2
`define ACMC_FILT_SINC4 3'h3
`define ACMC_FILT_FIR 3'h4
`define ACMC_CHOP_NORMAL 2'h0
`define ACMC_CHOP_SWAP 2'h1
`define ACMC_CHOP_AC2 2'h2
`define ACMC_CHOP_AC4 2'h3
`define ACMC_RATE_25600 5'h0F
`define ACMC_DLY_ZERO 4'h0

// ==========================================================
// Timing: clock rate and start delays in microseconds
`define ACMC_CLK_MHZ 250
`define ACMC_TICK_US 1
`define ACMC_DLY_US_0 15'd0
`define ACMC_DLY_US_1 15'd50
`define ACMC_DLY_US_2 15'd59
`define ACMC_DLY_US_3 15'd67
`define ACMC_DLY_US_4 15'd85
`define ACMC_DLY_US_5 15'd119
`define ACMC_DLY_US_6 15'd189
`define ACMC_DLY_US_7 15'd328
`define ACMC_DLY_US_8 15'd605
`define ACMC_DLY_US_9 15'd1160
`define ACMC_DLY_US_10 15'd2270
`define ACMC_DLY_US_11 15'd4490
`define ACMC_DLY_US_12 15'd8930
`define ACMC_DLY_US_13 15'd17800

`endif

// >>> logic/acmc_mode_regs.v
// Conversion-mode register bank of a delta-sigma converter: rate and
// filter select, conversion control with start delay, aux pin setup.
// Assumes a plain register port with read data one cycle after the strobe,
// and lock/unlock commands arriving as one-cycle pulses.
//
// How it works
// - Rate code sits in bits 7:3 of register 02h, resets to 20 SPS.
// - Codes 0-15 give the listed rates; codes 16-31 give 40000 SPS.
// - Filter bits 2:0 select sinc1 to sinc4 or FIR; 101-111 reserved.
// - Register 02h resets to 24h.
// - Bits 6:5 of 03h: normal, swap, two-wire or four-wire excitation.
// - Bit 4 of 03h: 0 continuous conversions, 1 single shot.
// - Bits 3:0 of 03h choose the start delay; 1110 and 1111 reserved.
// - Register 03h resets to 01h.
// - Register 04h resets to 00h; upper nibble links, lower directions.
// - Writes are accepted only while unlocked; unlocked after reset.
// - Link bits 7:4 attach aux pins 3:0 to analog inputs 5:2.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "acmc_map.vh"

module acmc_mode_regs
#(
   parameter HAS_AUX = 1,
   parameter TICK_DIV = `ACMC_CLK_MHZ * `ACMC_TICK_US
)
(
   input wire clk,
   input wire reset_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire cmd_lock,
   input wire cmd_unlock,
   output reg lock_status,
   input wire conv_start,
   output wire conv_go,
   output wire delay_busy,
   output reg [4:0] output_rate_code,
   output reg [18:0] rate_dsps,
   output reg [4:0] filter_onehot,
   output reg filter_code_bad,
   output reg [3:0] chop_onehot,
   output reg single_shot_select,
   output reg [3:0] start_delay_code,
   output reg delay_code_bad,
   output reg zero_delay_misuse,
   output reg [3:0] aux_pin_analog_link,
   output reg [3:0] aux_pin_input_dir
);

   // ==========================================================
   // Storage
   reg [7:0] rate_and_filter_select_r;
   reg [7:0] conversion_control_r;
   reg [7:0] aux_pin_setup_r;
   reg lock_r;
   reg [7:0] rdata_nxt;
   reg [18:0] rate_nxt;
   reg [14:0] delay_us_nxt;
   reg [4:0] filt_nxt;
   reg [3:0] chop_nxt;
   wire wr_ok;
   wire start_ok;
   wire tick;
   wire [4:0] rate_code;
   wire [2:0] filt_code;
   wire [1:0] chop_code;
   wire [3:0] dly_code;
   wire [3:0] link_nxt;
   wire [3:0] dir_nxt;
   genvar pin_g;

   // ==========================================================
   // Field views of the stored registers
   // Decodes below read these views, except the shot bit and the aux pin bits, which read the raw bytes
   assign rate_code = rate_and_filter_select_r[`ACMC_RATE_MSB:`ACMC_RATE_LSB];
   assign filt_code = rate_and_filter_select_r[`ACMC_FILT_MSB:`ACMC_FILT_LSB];
   assign chop_code = conversion_control_r[`ACMC_CHOP_MSB:`ACMC_CHOP_LSB];
   assign dly_code = conversion_control_r[`ACMC_DLY_MSB:`ACMC_DLY_LSB];

   // ==========================================================
   // Write gate: writes pass only while unlocked
   // A dropped write raises no flag; software reads back to confirm
   assign wr_ok = reg_wr && !lock_r;

   // ==========================================================
   // Lock state; a lock in the same cycle as an unlock wins
   // so a host racing both commands never opens the bank by accident
   // Lock status is shown one edge after this state
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         lock_r <= 1'b0;
      else if (cmd_lock)
         lock_r <= 1'b1;
      else if (cmd_unlock)
         lock_r <= 1'b0;
   end

   // ==========================================================
   // Register writes
   // Whole bytes are kept, reserved bits too, so reads return what was written
   // Unmapped addresses fall through and change nothing
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rate_and_filter_select_r <= `ACMC_RST_RATE_FILT;
         conversion_control_r <= `ACMC_RST_CONV_CTRL;
         aux_pin_setup_r <= `ACMC_RST_AUX_PIN;
      end
      else if (wr_ok)
      begin
         case (reg_addr)
            `ACMC_ADDR_RATE_FILT:
               rate_and_filter_select_r <= reg_wdata;
            `ACMC_ADDR_CONV_CTRL:
               conversion_control_r <= reg_wdata;
            `ACMC_ADDR_AUX_PIN:
               aux_pin_setup_r <= reg_wdata;
            default:
               aux_pin_setup_r <= aux_pin_setup_r;
         endcase
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero
   // The address is looked at in the strobe cycle only
   always @*
   begin
      rdata_nxt = `ACMC_RST_RDATA;
      case (reg_addr)
         `ACMC_ADDR_RATE_FILT:
            rdata_nxt = rate_and_filter_select_r;
         `ACMC_ADDR_CONV_CTRL:
            rdata_nxt = conversion_control_r;
         `ACMC_ADDR_AUX_PIN:
            rdata_nxt = aux_pin_setup_r;
         default:
            rdata_nxt = `ACMC_RST_RDATA;
      endcase
   end

   // Read data stands in the cycle after the strobe only
   // and clears afterwards, so a stale byte never lingers
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= `ACMC_RST_RDATA;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
      else
         reg_rdata <= `ACMC_RST_RDATA;
   end

   // ==========================================================
   // Rate code to output rate in tenths of a sample per second
   // Tenths keep 2.5 and 16.6 SPS exact as integers
   // Codes 16 and up all give the fastest rate
   always @*
   begin
      rate_nxt = 19'd400000;
      case (rate_code)
         5'h00: rate_nxt = 19'd25;
         5'h01: rate_nxt = 19'd50;
         5'h02: rate_nxt = 19'd100;
         5'h03: rate_nxt = 19'd166;
         5'h04: rate_nxt = 19'd200;
         5'h05: rate_nxt = 19'd500;
         5'h06: rate_nxt = 19'd600;
         5'h07: rate_nxt = 19'd1000;
         5'h08: rate_nxt = 19'd4000;
         5'h09: rate_nxt = 19'd12000;
         5'h0A: rate_nxt = 19'd24000;
         5'h0B: rate_nxt = 19'd48000;
         5'h0C: rate_nxt = 19'd72000;
         5'h0D: rate_nxt = 19'd144000;
         5'h0E: rate_nxt = 19'd192000;
         5'h0F: rate_nxt = 19'd256000;
         default: rate_nxt = 19'd400000;
      endcase
   end

   // ==========================================================
   // Filter code to one-hot select, bit n for sinc(n+1), bit 4 for FIR
   // Reserved codes give no select at all; the bad-code flag reports them
   always @*
   begin
      filt_nxt = 5'h00;
      case (filt_code)
         `ACMC_FILT_SINC1: filt_nxt = 5'h01;
         `ACMC_FILT_SINC2: filt_nxt = 5'h02;
         `ACMC_FILT_SINC3: filt_nxt = 5'h04;
         `ACMC_FILT_SINC4: filt_nxt = 5'h08;
         `ACMC_FILT_FIR: filt_nxt = 5'h10;
         default: filt_nxt = 5'h00;
      endcase
   end

   // ==========================================================
   // Chop and excitation mode; excitation only on the larger variant
   // The smaller variant has no excitation drivers, so it falls back to normal
   always @*
   begin
      chop_nxt = 4'h1;
      case (chop_code)
         `ACMC_CHOP_NORMAL: chop_nxt = 4'h1;
         `ACMC_CHOP_SWAP: chop_nxt = 4'h2;
         `ACMC_CHOP_AC2: chop_nxt = (HAS_AUX != 0) ? 4'h4 : 4'h1;
         `ACMC_CHOP_AC4: chop_nxt = (HAS_AUX != 0) ? 4'h8 : 4'h1;
         default: chop_nxt = 4'h1;
      endcase
   end

   // ==========================================================
   // Start delay code to microseconds; reserved codes take the longest
   // so a bad setting errs on the slow, settled side
   // Times hold at the nominal modulator clock through TICK_DIV
   always @*
   begin
      delay_us_nxt = `ACMC_DLY_US_13;
      case (dly_code)
         4'h0: delay_us_nxt = `ACMC_DLY_US_0;
         4'h1: delay_us_nxt = `ACMC_DLY_US_1;
         4'h2: delay_us_nxt = `ACMC_DLY_US_2;
         4'h3: delay_us_nxt = `ACMC_DLY_US_3;
         4'h4: delay_us_nxt = `ACMC_DLY_US_4;
         4'h5: delay_us_nxt = `ACMC_DLY_US_5;
         4'h6: delay_us_nxt = `ACMC_DLY_US_6;
         4'h7: delay_us_nxt = `ACMC_DLY_US_7;
         4'h8: delay_us_nxt = `ACMC_DLY_US_8;
         4'h9: delay_us_nxt = `ACMC_DLY_US_9;
         4'hA: delay_us_nxt = `ACMC_DLY_US_10;
         4'hB: delay_us_nxt = `ACMC_DLY_US_11;
         4'hC: delay_us_nxt = `ACMC_DLY_US_12;
         4'hD: delay_us_nxt = `ACMC_DLY_US_13;
         default: delay_us_nxt = `ACMC_DLY_US_13;
      endcase
   end

   // ==========================================================
   // Registered decoded outputs, one edge behind the stored fields
   // Flops keep decode glitches off the pins at the cost of one cycle
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lock_status <= 1'b0;
         output_rate_code <= 5'h04;
         rate_dsps <= 19'd200;
         filter_onehot <= 5'h10;
         filter_code_bad <= 1'b0;
      end
      else
      begin
         lock_status <= lock_r;
         output_rate_code <= rate_code;
         rate_dsps <= rate_nxt;
         filter_onehot <= filt_nxt;
         filter_code_bad <= (filt_code > `ACMC_FILT_FIR);
      end
   end

   // Conversion control outputs
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         chop_onehot <= 4'h1;
         single_shot_select <= 1'b0;
         start_delay_code <= 4'h1;
         delay_code_bad <= 1'b0;
         zero_delay_misuse <= 1'b0;
      end
      else
      begin
         chop_onehot <= chop_nxt;
         single_shot_select <= conversion_control_r[`ACMC_SHOT_BIT];
         start_delay_code <= dly_code;
         delay_code_bad <= (dly_code > 4'hD);
         // Flags a forbidden zero delay at the two fastest rates
         zero_delay_misuse <= (dly_code == `ACMC_DLY_ZERO) && (rate_code >= `ACMC_RATE_25600);
      end
   end

   // Aux pin outputs
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aux_pin_analog_link <= 4'h0;
         aux_pin_input_dir <= 4'h0;
      end
      else
      begin
         aux_pin_analog_link <= link_nxt;
         aux_pin_input_dir <= dir_nxt;
      end
   end

   // ==========================================================
   // Per aux pin: pin n links to analog input n+2; zero on the smaller variant
   generate
      for (pin_g = 0; pin_g < 4; pin_g = pin_g + 1)
      begin : g_aux_pin
         // Link bit 4+n and direction bit n of register 04h
         assign link_nxt[pin_g] = (HAS_AUX != 0) && aux_pin_setup_r[`ACMC_LINK_LSB + pin_g];
         assign dir_nxt[pin_g] = (HAS_AUX != 0) && aux_pin_setup_r[`ACMC_DIR_LSB + pin_g];
      end
   endgenerate

   // ==========================================================
   // Conversion start: accepted only while no delay is running
   // Starts during a delay are dropped, not queued; wait for the pulse
   // The timer reads the delay code live at the start edge
   assign start_ok = conv_start && !delay_busy;

   // Microsecond tick, restarted by each accepted start so delays are exact
   // The first tick then lands one full period after the start edge
   acmc_tick_div
   #(
      .DIV(TICK_DIV),
      .CW(16)
   )
   u_tick
   (
      .clk(clk),
      .reset_n(reset_n),
      .clr(start_ok),
      .tick(tick)
   );

   // Start-delay timer; its outputs are flip-flops
   acmc_start_delay u_delay
   (
      .clk(clk),
      .reset_n(reset_n),
      .start(start_ok),
      .tick(tick),
      .delay_us(delay_us_nxt),
      .busy(delay_busy),
      .go(conv_go)
   );

endmodule // acmc_mode_regs

// >>> logic/acmc_start_delay.v
// Conversion-start delay timer counting microsecond ticks.
// Assumes tick is a one-cycle enable restarted with each accepted start.
`timescale 1ns/1ps
module acmc_start_delay
(
   input wire clk,
   input wire reset_n,
   input wire start,
   input wire tick,
   input wire [14:0] delay_us,
   output reg busy,
   output reg go
);
   reg [14:0] remain_r;

   // ==========================================================
   // Countdown; zero delay fires on the next edge
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busy <= 1'b0;
         go <= 1'b0;
         remain_r <= 15'h0000;
      end
      else
      begin
         go <= 1'b0;
         if (start && !busy)
         begin
            if (delay_us == 15'h0000)
               go <= 1'b1;
            else
            begin
               busy <= 1'b1;
               remain_r <= delay_us;
            end
         end
         else if (busy && tick)
         begin
            if (remain_r == 15'h0001)
            begin
               busy <= 1'b0;
               go <= 1'b1; // Delay elapsed
            end
            else
               remain_r <= remain_r - 1'b1;
         end
      end
   end
endmodule // acmc_start_delay

// >>> logic/acmc_tick_div.v
// Divider that gives a one-cycle enable pulse every DIV clocks.
// Assumes a synchronous clear that restarts the period.
`timescale 1ns/1ps
module acmc_tick_div
#(
   parameter DIV = 250,
   parameter CW = 16
)
(
   input wire clk,
   input wire reset_n,
   input wire clr,
   output reg tick
);
   reg [CW-1:0] cnt_r;

   // ==========================================================
   // Period counter
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_r <= {CW{1'b0}};
         tick <= 1'b0;
      end
      else if (clr)
      begin
         cnt_r <= {CW{1'b0}};
         tick <= 1'b0;
      end
      else if (cnt_r == DIV[CW-1:0] - 1'b1)
      begin
         cnt_r <= {CW{1'b0}};
         tick <= 1'b1; // One pulse per period
      end
      else
      begin
         cnt_r <= cnt_r + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule // acmc_tick_div

// >>> sim/acmc_host_model.sv
// Host that programs the mode registers over the plain register port.
// Assumes read data one cycle after the strobe and a bank that never stalls.
`timescale 1ns/1ps
module acmc_host_model
(
   input wire clk,
   input wire [7:0] reg_rdata,
   output reg [7:0] reg_addr,
   output reg [7:0] reg_wdata,
   output reg reg_wr,
   output reg reg_rd,
   output reg cmd_lock,
   output reg cmd_unlock,
   output reg conv_start
);
   reg [4:0] rate_r;
   reg [3:0] dly_r;

   // Idle bus at time zero
   initial
   begin
      {reg_addr, reg_wdata} = 16'h0000;
      {reg_wr, reg_rd, cmd_lock, cmd_unlock, conv_start} = 5'h00;
      rate_r = 5'h04;
      dly_r = 4'h1;
   end

   // One-cycle write; reserved filter codes, bit 7 of 03h and forbidden pairs kept out; reserved delay codes pass
   task wr(input [7:0] a, input [7:0] d);
      reg [7:0] v;
      begin
         v = d;
         if (a == 8'h02 && v[2:0] > 3'h4)
            v[2:0] = 3'h4;
         if (a == 8'h02 && v[7:3] >= 5'h0F && dly_r == 4'h0)
            v[7:3] = 5'h0E;
         if (a == 8'h03)
            v[7] = 1'b0;
         if (a == 8'h03 && v[3:0] == 4'h0 && rate_r >= 5'h0F)
            v[3:0] = 4'h1;
         if (a == 8'h02)
            rate_r = v[7:3];
         if (a == 8'h03)
            dly_r = v[3:0];
         @(posedge clk);
         reg_addr <= a;
         reg_wdata <= v;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
         reg_addr <= ~a; // Released lines show no stale value
         reg_wdata <= ~v;
      end
   endtask

   // One-cycle read; data taken in the cycle after the strobe
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         reg_addr <= ~a;
         #1;
         d = reg_rdata;
      end
   endtask

   // One-cycle pulse of start, unlock or lock
   task cmd(input [2:0] sel);
      begin
         @(posedge clk);
         {conv_start, cmd_unlock, cmd_lock} <= sel;
         @(posedge clk);
         {conv_start, cmd_unlock, cmd_lock} <= 3'b000;
      end
   endtask
endmodule // acmc_host_model

// >>> sim/acmc_mode_sva.sv
// Checker for the conversion-mode register bank, watching its ports only.
// Assumes a bind onto acmc_mode_regs and one clock domain.
`timescale 1ns/1ps
module acmc_mode_sva
#(
   parameter TICK_DIV = 2
)
(
   input wire clk,
   input wire reset_n,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire cmd_lock,
   input wire lock_status,
   input wire conv_start,
   input wire conv_go,
   input wire delay_busy,
   input wire [4:0] output_rate_code,
   input wire [4:0] filter_onehot,
   input wire filter_code_bad,
   input wire [3:0] chop_onehot,
   input wire [3:0] start_delay_code,
   input wire [3:0] aux_pin_analog_link,
   input wire [3:0] aux_pin_input_dir
);
   // Start-to-pulse span for the 50 us default delay
   localparam int GO_DLY = 50 * TICK_DIV + 1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // Register views
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_rate_view;
      reg_rd && reg_addr == 8'h02 |=> reg_rdata[7:3] == output_rate_code;
   endproperty
   a_rate_view: assert property (p_rate_view) else $error("rate field mismatch");
   property p_dly_view;
      reg_rd && reg_addr == 8'h03 |=> reg_rdata[3:0] == start_delay_code;
   endproperty
   a_dly_view: assert property (p_dly_view) else $error("delay field mismatch");
   property p_aux_view;
      reg_rd && reg_addr == 8'h04 |=> reg_rdata == {aux_pin_analog_link, aux_pin_input_dir};
   endproperty
   a_aux_view: assert property (p_aux_view) else $error("aux fields mismatch");
   property p_filt_dec;
      !filter_code_bad |-> $onehot(filter_onehot);
   endproperty
   a_filt_dec: assert property (p_filt_dec) else $error("filter decode broken");
   property p_chop_dec;
      $onehot(chop_onehot);
   endproperty
   a_chop_dec: assert property (p_chop_dec) else $error("chop decode broken");

   // ==========================================================
   // Start delay and lock
   property p_go_dly;
      conv_start && !delay_busy && start_delay_code == 4'h1 |=> ##[GO_DLY:GO_DLY] conv_go;
   endproperty
   a_go_dly: assert property (p_go_dly) else $error("start pulse late or early");
   property p_go_zero;
      conv_start && !delay_busy && start_delay_code == 4'h0 |=> conv_go;
   endproperty
   a_go_zero: assert property (p_go_zero) else $error("zero delay pulse missing");
   property p_busy_end;
      $fell(delay_busy) |-> conv_go;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy ended without pulse");
   property p_lock;
      cmd_lock |=> ##1 lock_status;
   endproperty
   a_lock: assert property (p_lock) else $error("lock not shown");
   property p_lock_drop;
      (reg_wr && reg_addr == 8'h02) ##1 lock_status |=> $stable(output_rate_code) [*2];
   endproperty
   a_lock_drop: assert property (p_lock_drop) else $error("locked write took effect");

   // Main scenarios reached
   c_go: cover property (conv_go);
   c_locked_wr: cover property (lock_status && reg_wr);
   c_aux_rd: cover property (reg_rd && reg_addr == 8'h04);
endmodule // acmc_mode_sva

bind acmc_mode_regs acmc_mode_sva #(.TICK_DIV(TICK_DIV)) acmc_mode_sva_inst
(
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .cmd_lock(cmd_lock), .lock_status(lock_status), .conv_start(conv_start),
   .conv_go(conv_go), .delay_busy(delay_busy), .output_rate_code(output_rate_code),
   .filter_onehot(filter_onehot), .filter_code_bad(filter_code_bad), .chop_onehot(chop_onehot),
   .start_delay_code(start_delay_code), .aux_pin_analog_link(aux_pin_analog_link),
   .aux_pin_input_dir(aux_pin_input_dir)
);

// >>> sim/tb_adc_conversion_mode_config.sv
// Self-checking bench for the conversion-mode register bank.
// Assumes the host model drives every bank input but clock and reset; delays use 2 cycles per us.
`timescale 1ns/1ps
module tb_adc_conversion_mode_config;
   reg clk;
   reg reset_n;
   wire [7:0] reg_addr, reg_wdata, reg_rdata;
   wire reg_wr, reg_rd, cmd_lock, cmd_unlock, conv_start, conv_go, delay_busy, lock_status;
   wire [4:0] output_rate_code, filter_onehot;
   wire [18:0] rate_dsps;
   wire filter_code_bad, single_shot_select, delay_code_bad, zero_delay_misuse;
   wire [3:0] chop_onehot, start_delay_code, aux_pin_analog_link, aux_pin_input_dir;
   integer bad_count, cmp_count, i, n;
   reg [7:0] d;
   reg [18:0] rtab [0:15] = '{19'd25, 19'd50, 19'd100, 19'd166, 19'd200, 19'd500, 19'd600, 19'd1000,
      19'd4000, 19'd12000, 19'd24000, 19'd48000, 19'd72000, 19'd144000, 19'd192000, 19'd256000};
   reg [14:0] dtab [0:3] = '{15'd0, 15'd50, 15'd59, 15'd67};

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   acmc_mode_regs #(.HAS_AUX(1), .TICK_DIV(2)) acmc_mode_regs_inst
   (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_lock(cmd_lock), .cmd_unlock(cmd_unlock),
      .lock_status(lock_status), .conv_start(conv_start), .conv_go(conv_go), .delay_busy(delay_busy),
      .output_rate_code(output_rate_code), .rate_dsps(rate_dsps), .filter_onehot(filter_onehot),
      .filter_code_bad(filter_code_bad), .chop_onehot(chop_onehot), .single_shot_select(single_shot_select),
      .start_delay_code(start_delay_code), .delay_code_bad(delay_code_bad),
      .zero_delay_misuse(zero_delay_misuse), .aux_pin_analog_link(aux_pin_analog_link),
      .aux_pin_input_dir(aux_pin_input_dir)
   );

   acmc_host_model acmc_host_model_inst
   (
      .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .cmd_lock(cmd_lock), .cmd_unlock(cmd_unlock), .conv_start(conv_start)
   );

   // Compare one value and count it
   task chk(input [18:0] got, input [18:0] exp, input string what);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
         end
      end
   endtask

   // Read a register and compare it
   task rdc(input [7:0] a, input [7:0] exp);
      begin
         acmc_host_model_inst.rd(a, d);
         chk(d, exp, "read data");
      end
   endtask

   // Count edges from the start edge to the start pulse, bounded
   task wait_go;
      begin
         n = 0;
         #1;
         while (conv_go !== 1'b1 && n < 400)
         begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         if (n >= 400)
         begin
            bad_count = bad_count + 1;
            $display("BAD %0t start pulse missing", $time);
            final_report;
         end
      end
   endtask

   // Verdict and end of run
   task final_report;
      begin
         $display("compares %0d mismatches %0d", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask

   // ==========================================================
   // Test sequence
   initial
   begin
      reset_n = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rdc(8'h02, 8'h24);
      rdc(8'h03, 8'h01);
      rdc(8'h04, 8'h00);
      rdc(8'h05, 8'h00);
      chk(rate_dsps, 19'd200, "reset rate");
      chk(lock_status, 1'b0, "reset lock");
      $display("test reset done");
      for (i = 0; i < 32; i = i + 1)
      begin
         acmc_host_model_inst.wr(8'h02, {i[4:0], 3'h4});
         rdc(8'h02, {i[4:0], 3'h4});
         chk(rate_dsps, (i > 15) ? 19'd400000 : rtab[i], "rate");
         chk(output_rate_code, i[4:0], "rate code");
      end
      for (i = 0; i < 5; i = i + 1)
      begin
         acmc_host_model_inst.wr(8'h02, {5'h04, i[2:0]});
         rdc(8'h02, {5'h04, i[2:0]});
         chk(filter_onehot, 5'h01 << i, "filter");
         chk(filter_code_bad, 1'b0, "filter bad");
      end
      $display("test rate and filter done");
      for (i = 0; i < 8; i = i + 1)
      begin
         acmc_host_model_inst.wr(8'h03, {1'b1, i[1:0], i[2], 4'h1});
         rdc(8'h03, {1'b0, i[1:0], i[2], 4'h1});
         chk(chop_onehot, 4'h1 << i[1:0], "chop");
         chk(single_shot_select, i[2], "shot");
      end
      acmc_host_model_inst.wr(8'h04, 8'hA5);
      rdc(8'h04, 8'hA5);
      chk({aux_pin_analog_link, aux_pin_input_dir}, 8'hA5, "aux");
      $display("test control and aux done");
      acmc_host_model_inst.cmd(3'b001);
      acmc_host_model_inst.wr(8'h02, 8'h14);
      rdc(8'h02, 8'h24);
      chk(lock_status, 1'b1, "locked");
      acmc_host_model_inst.cmd(3'b010);
      acmc_host_model_inst.wr(8'h02, 8'h14);
      rdc(8'h02, 8'h14);
      $display("test lock done");
      for (i = 0; i < 4; i = i + 1)
      begin
         acmc_host_model_inst.wr(8'h03, i[7:0]);
         rdc(8'h03, i[7:0]);
         chk(start_delay_code, i[3:0], "delay code");
         acmc_host_model_inst.cmd(3'b100);
         #1;
         chk(delay_busy, (i != 0), "busy");
         wait_go;
         chk(n, (i == 0) ? 19'd0 : dtab[i] * 2 + 1, "delay edges");
         chk(delay_busy, 1'b0, "busy end");
         chk(zero_delay_misuse, 1'b0, "misuse");
      end
      acmc_host_model_inst.wr(8'h03, 8'h0E);
      rdc(8'h03, 8'h0E);
      chk(delay_code_bad, 1'b1, "reserved delay");
      $display("test start delay done");
      final_report;
   end
endmodule // tb_adc_conversion_mode_config
